//--- design/udlm_defines.svh
`ifndef UDLM_DEFINES_SVH
`define UDLM_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses on the control bus)
// ----------------------------------------------------------------
`define UDLM_OFF_DP_HI 8'h43
`define UDLM_OFF_DP_LO 8'h44
`define UDLM_OFF_DM_HI 8'h45
`define UDLM_OFF_DM_LO 8'h46
`define UDLM_OFF_CTRL 8'h47
`define UDLM_OFF_ID 8'h48

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UDLM_DP_SEL_MSB 7
`define UDLM_DP_SEL_LSB 5
`define UDLM_DM_SEL_MSB 4
`define UDLM_DM_SEL_LSB 2
`define UDLM_HI_MSB 15
`define UDLM_HI_LSB 8
`define UDLM_LO_MSB 7
`define UDLM_LO_LSB 0

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define UDLM_CTRL_RESET 8'h00
`define UDLM_RESULT_RESET 16'h0000
`define UDLM_BYTE_ZERO 8'h00
`define UDLM_ID_RSV 2'h0
`define UDLM_RESULT_MAX 16'h0e10
`define UDLM_SEL_ZERO 3'h0

// ----------------------------------------------------------------
// measured lines
// ----------------------------------------------------------------
`define UDLM_LINE_COUNT 2
`define UDLM_CH_DP 0
`define UDLM_CH_DM 1

`endif

//--- design/udlm_pkg.sv
package udlm_pkg;

   // drive level codes shared by both line selects
   typedef enum logic [2:0] {
      UDLM_HIGH_IMPEDANCE = 3'b000,
      UDLM_GROUND = 3'b001,
      UDLM_LEVEL_0P6 = 3'b010,
      UDLM_LEVEL_1P2 = 3'b011,
      UDLM_LEVEL_2P0 = 3'b100,
      UDLM_LEVEL_2P7 = 3'b101,
      UDLM_LEVEL_3P3 = 3'b110,
      UDLM_SHORT = 3'b111
   } udlm_drive_e;

   typedef logic [15:0] udlm_result_t;

endpackage : udlm_pkg

//--- design/udlm_result_hold.sv
`timescale 1ns/10ps
`include "udlm_defines.svh"

module udlm_result_hold (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic sample_in,
   input wire udlm_pkg::udlm_result_t value_in,
   output udlm_pkg::udlm_result_t result_out
);

   // ----------------------------------------------------------------
   // result capture
   // ----------------------------------------------------------------
   // converter codes above full scale are clamped so software never
   // sees a value outside the documented range
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         result_out <= `UDLM_RESULT_RESET;
      end else if (sample_in) begin
         if (value_in > `UDLM_RESULT_MAX) begin
            result_out <= `UDLM_RESULT_MAX;
         end else begin
            result_out <= value_in;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_result_range;
      @(posedge clk_in) disable iff (!reset_n_in)
      sample_in |=> (result_out <= `UDLM_RESULT_MAX) &&
         (result_out == (($past(value_in) > `UDLM_RESULT_MAX) ?
         `UDLM_RESULT_MAX : $past(value_in)));
   endproperty
   a_result_range: assert property (p_result_range)
      else $error("result not captured or out of range");

endmodule : udlm_result_hold

//--- design/udlm_regs.sv
// Overview of operation
// - read-only 16-bit D+ voltage result at 43h, 1 mV steps, 0-3600, resets zero.
// - read-only 16-bit D- voltage result at 45h, same scale, resets zero.
// - D+ drive select bits 7-5, reset zero: hi-Z, ground, five fixed levels.
// - D+ drive code 7 shorts D+ to D- instead of driving a level.
// - D- drive select bits 4-2, reset zero, same codes; code 7 reserved.
// - identification bits 5-3 hold the part code; bits 7-6 read zero.
// - identification bits 2-0 hold a fixed revision code.
`timescale 1ns/10ps
`include "udlm_defines.svh"

module udlm_regs #(
   // arbitrary neutral identification values
   parameter logic [2:0] PART_CODE = 3'h5,
   parameter logic [2:0] REVISION_CODE = 3'h2
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic conv_valid_in,
   input wire udlm_pkg::udlm_result_t dp_line_voltage_in,
   input wire udlm_pkg::udlm_result_t dm_line_voltage_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rvalid_out,
   output udlm_pkg::udlm_drive_e dp_line_drive_select_out,
   output udlm_pkg::udlm_drive_e dm_line_drive_select_out,
   output logic dpdm_short_out
);

   // ----------------------------------------------------------------
   // converter results
   // ----------------------------------------------------------------
   udlm_pkg::udlm_result_t dp_line_voltage_result;
   udlm_pkg::udlm_result_t dm_line_voltage_result;
   logic [7:0] dp_lo_snap;
   logic [7:0] dm_lo_snap;
   logic [7:0] ctrl;
   logic [7:0] next_rdata;
   logic [7:0] id_value;
   logic [2:0] dp_code;
   logic [2:0] dm_code;

   // both lines use one capture module, one instance each, so their clamping cannot drift apart
   udlm_pkg::udlm_result_t line_voltage_in [`UDLM_LINE_COUNT];
   udlm_pkg::udlm_result_t line_voltage_result [`UDLM_LINE_COUNT];

   assign line_voltage_in[`UDLM_CH_DP] = dp_line_voltage_in;
   assign line_voltage_in[`UDLM_CH_DM] = dm_line_voltage_in;
   assign dp_line_voltage_result = line_voltage_result[`UDLM_CH_DP];
   assign dm_line_voltage_result = line_voltage_result[`UDLM_CH_DM];

   for (genvar ch = 0; ch < `UDLM_LINE_COUNT; ch++) begin : g_hold
      udlm_result_hold u_hold (
         .clk_in(clk_in),
         .reset_n_in(reset_n_in),
         .sample_in(conv_valid_in),
         .value_in(line_voltage_in[ch]),
         .result_out(line_voltage_result[ch])
      );
   end

   // reading the high byte freezes the low byte, so a high-then-low
   // read pair is coherent even if a new conversion lands in between
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dp_lo_snap <= `UDLM_BYTE_ZERO;
         dm_lo_snap <= `UDLM_BYTE_ZERO;
      end else if (reg_rd_in) begin
         if (reg_addr_in == `UDLM_OFF_DP_HI) begin
            dp_lo_snap <= dp_line_voltage_result[`UDLM_LO_MSB:`UDLM_LO_LSB];
         end
         if (reg_addr_in == `UDLM_OFF_DM_HI) begin
            dm_lo_snap <= dm_line_voltage_result[`UDLM_LO_MSB:`UDLM_LO_LSB];
         end
      end
   end

   // ----------------------------------------------------------------
   // drive control register
   // ----------------------------------------------------------------
   // only the control offset is writable; all other writes are dropped
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ctrl <= `UDLM_CTRL_RESET;
      end else if (reg_wr_in && (reg_addr_in == `UDLM_OFF_CTRL)) begin
         ctrl <= reg_wdata_in;
      end
   end

   assign dp_code = ctrl[`UDLM_DP_SEL_MSB:`UDLM_DP_SEL_LSB];
   assign dm_code = ctrl[`UDLM_DM_SEL_MSB:`UDLM_DM_SEL_LSB];

   // ----------------------------------------------------------------
   // line drivers
   // ----------------------------------------------------------------
   // a short leaves both level drivers off so no level fights the short;
   // a reserved D- code is held safe as high impedance
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dp_line_drive_select_out <= udlm_pkg::UDLM_HIGH_IMPEDANCE;
         dm_line_drive_select_out <= udlm_pkg::UDLM_HIGH_IMPEDANCE;
         dpdm_short_out <= 1'b0;
      end else begin
         case (dp_code)
            udlm_pkg::UDLM_SHORT: begin
               dp_line_drive_select_out <= udlm_pkg::UDLM_HIGH_IMPEDANCE;
               dpdm_short_out <= 1'b1;
            end
            default: begin
               dp_line_drive_select_out <= udlm_pkg::udlm_drive_e'(dp_code);
               dpdm_short_out <= 1'b0;
            end
         endcase
         if ((dp_code == udlm_pkg::UDLM_SHORT) || (dm_code == udlm_pkg::UDLM_SHORT)) begin
            dm_line_drive_select_out <= udlm_pkg::UDLM_HIGH_IMPEDANCE;
         end else begin
            dm_line_drive_select_out <= udlm_pkg::udlm_drive_e'(dm_code);
         end
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   assign id_value = {`UDLM_ID_RSV, PART_CODE, REVISION_CODE};

   always_comb begin
      case (reg_addr_in)
         `UDLM_OFF_DP_HI: next_rdata = dp_line_voltage_result[`UDLM_HI_MSB:`UDLM_HI_LSB];
         `UDLM_OFF_DP_LO: next_rdata = dp_lo_snap;
         `UDLM_OFF_DM_HI: next_rdata = dm_line_voltage_result[`UDLM_HI_MSB:`UDLM_HI_LSB];
         `UDLM_OFF_DM_LO: next_rdata = dm_lo_snap;
         `UDLM_OFF_CTRL: next_rdata = ctrl;
         `UDLM_OFF_ID: next_rdata = id_value;
         default: next_rdata = `UDLM_BYTE_ZERO;
      endcase
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         reg_rdata_out <= `UDLM_BYTE_ZERO;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in) begin
            reg_rdata_out <= next_rdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_read(logic [7:0] off);
      reg_rd_in && (reg_addr_in == off);
   endsequence

   sequence s_ctrl_write;
      reg_wr_in && (reg_addr_in == `UDLM_OFF_CTRL);
   endsequence

   property p_dp_read;
      @(posedge clk_in) disable iff (!reset_n_in)
      s_read(`UDLM_OFF_DP_HI) ##1 s_read(`UDLM_OFF_DP_LO) |=>
         reg_rvalid_out &&
         (reg_rdata_out == $past(dp_line_voltage_result[`UDLM_LO_MSB:`UDLM_LO_LSB], 2));
   endproperty
   a_dp_read: assert property (p_dp_read)
      else $error("D+ low byte not coherent with high byte");

   property p_dm_hi_read;
      @(posedge clk_in) disable iff (!reset_n_in)
      s_read(`UDLM_OFF_DM_HI) |=> reg_rvalid_out &&
         (reg_rdata_out == $past(dm_line_voltage_result[15:8]));
   endproperty
   a_dm_hi_read: assert property (p_dm_hi_read)
      else $error("D- high byte read mismatch");

   property p_dp_level;
      logic [2:0] code;
      @(posedge clk_in) disable iff (!reset_n_in)
      (s_ctrl_write, code = reg_wdata_in[7:5]) ##1 (code != 3'h7) |=>
         (dp_line_drive_select_out == code) && !dpdm_short_out;
   endproperty
   a_dp_level: assert property (p_dp_level)
      else $error("D+ drive select did not follow written code");

   property p_short;
      @(posedge clk_in) disable iff (!reset_n_in)
      (dp_code == 3'h7) |=> dpdm_short_out &&
         (dp_line_drive_select_out == udlm_pkg::UDLM_HIGH_IMPEDANCE) &&
         (dm_line_drive_select_out == udlm_pkg::UDLM_HIGH_IMPEDANCE);
   endproperty
   a_short: assert property (p_short)
      else $error("D+ code 7 did not short the lines");

   property p_dm_level;
      @(posedge clk_in) disable iff (!reset_n_in)
      (dp_code != 3'h7) |=> (dm_line_drive_select_out ==
         (($past(dm_code) == 3'h7) ? 3'h0 : $past(dm_code)));
   endproperty
   a_dm_level: assert property (p_dm_level)
      else $error("D- drive select wrong");

   property p_id_read;
      @(posedge clk_in) disable iff (!reset_n_in)
      s_read(`UDLM_OFF_ID) |=> reg_rvalid_out && (reg_rdata_out[7:6] == 2'h0) &&
         (reg_rdata_out[5:3] == PART_CODE);
   endproperty
   a_id_read: assert property (p_id_read)
      else $error("identification part field wrong");

   property p_rev_read;
      @(posedge clk_in) disable iff (!reset_n_in)
      s_read(`UDLM_OFF_ID) |=> (reg_rdata_out[2:0] == REVISION_CODE);
   endproperty
   a_rev_read: assert property (p_rev_read)
      else $error("identification revision field wrong");

   property p_ro_write;
      @(posedge clk_in) disable iff (!reset_n_in)
      (reg_wr_in && (reg_addr_in != `UDLM_OFF_CTRL) && !conv_valid_in) |=>
         $stable(ctrl) && $stable(dp_line_voltage_result) &&
         $stable(dm_line_voltage_result);
   endproperty
   a_ro_write: assert property (p_ro_write)
      else $error("write to read-only register changed state");

endmodule : udlm_regs

//--- tb/udlm_testbench.sv
`timescale 1ns/10ps

module testbench;
   // arbitrary neutral identification values, different from the design defaults
   localparam logic [2:0] PART = 3'h3;
   localparam logic [2:0] REV = 3'h6;

   logic clk_in;
   logic reset_n_in;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic conv_valid;
   udlm_pkg::udlm_result_t dp_volt;
   udlm_pkg::udlm_result_t dm_volt;
   logic [7:0] rdata;
   logic rvalid;
   udlm_pkg::udlm_drive_e dp_sel;
   udlm_pkg::udlm_drive_e dm_sel;
   logic dpdm_short;
   int error_cnt = 0;
   int cmp_count = 0;

   udlm_regs #(.PART_CODE(PART), .REVISION_CODE(REV)) DUT (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata),
      .reg_wr_in(reg_wr),
      .reg_rd_in(reg_rd),
      .conv_valid_in(conv_valid),
      .dp_line_voltage_in(dp_volt),
      .dm_line_voltage_in(dm_volt),
      .reg_rdata_out(rdata),
      .reg_rvalid_out(rvalid),
      .dp_line_drive_select_out(dp_sel),
      .dm_line_drive_select_out(dm_sel),
      .dpdm_short_out(dpdm_short)
   );

   // ----------------------------------------------------------------
   // clock and helpers
   // ----------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   task test_done;
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done

   task check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task do_reset;
      @(negedge clk_in);
      reset_n_in = 1'b0;
      repeat (6) @(negedge clk_in);
      reset_n_in = 1'b1;
   endtask : do_reset

   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_in);
      reg_wr = 1'b0;
   endtask : wr_reg

   // rvalid must be high for exactly the cycle after the read edge
   task rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk_in);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_in);
      reg_rd = 1'b0;
      check(16'(rvalid), 16'h0001);
      check(16'(rdata), 16'(e));
      @(negedge clk_in);
      check(16'(rvalid), 16'h0000);
   endtask : rd_reg

   // outputs follow the control register one edge after the write edge
   task drv(input logic [7:0] w, input logic [2:0] edp, input logic [2:0] edm,
            input logic esh);
      wr_reg(8'h47, w);
      repeat (2) @(negedge clk_in);
      check(16'(dp_sel), 16'(edp));
      check(16'(dm_sel), 16'(edm));
      check(16'(dpdm_short), 16'(esh));
      rd_reg(8'h47, w);
   endtask : drv

   // high then low byte back to back while a new conversion lands on the
   // high-byte edge: both bytes must still come from the older result
   task rd_pair(input logic [7:0] a, input logic [15:0] vp, input logic [15:0] vm,
                input logic [15:0] e);
      @(negedge clk_in);
      reg_addr = a;
      reg_rd = 1'b1;
      dp_volt = vp;
      dm_volt = vm;
      conv_valid = 1'b1;
      @(negedge clk_in);
      reg_addr = a + 8'h01;
      conv_valid = 1'b0;
      check(16'(rvalid), 16'h0001);
      check(16'(rdata), 16'(e[15:8]));
      @(negedge clk_in);
      reg_rd = 1'b0;
      check(16'(rvalid), 16'h0001);
      check(16'(rdata), 16'(e[7:0]));
   endtask : rd_pair

   // inputs change after the pulse so only the sampled value may show
   task conv(input logic [15:0] vp, input logic [15:0] vm);
      @(negedge clk_in);
      dp_volt = vp;
      dm_volt = vm;
      conv_valid = 1'b1;
      @(negedge clk_in);
      conv_valid = 1'b0;
      dp_volt = 16'h0555;
      dm_volt = 16'h0aaa;
   endtask : conv

   // ----------------------------------------------------------------
   // stimulus
   // ----------------------------------------------------------------
   initial begin
      reset_n_in = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      conv_valid = 1'b0;
      dp_volt = 16'h0000;
      dm_volt = 16'h0000;
      do_reset;
      check(16'(dp_sel), 16'h0000);
      check(16'(dm_sel), 16'h0000);
      check(16'(dpdm_short), 16'h0000);
      rd_reg(8'h43, 8'h00);
      rd_reg(8'h44, 8'h00);
      rd_reg(8'h45, 8'h00);
      rd_reg(8'h46, 8'h00);
      rd_reg(8'h47, 8'h00);
      rd_reg(8'h48, {2'h0, PART, REV});
      conv(16'h0abc, 16'h0e10);
      rd_reg(8'h43, 8'h0a);
      rd_reg(8'h44, 8'hbc);
      rd_reg(8'h45, 8'h0e);
      rd_reg(8'h46, 8'h10);
      // values past full scale must read back as 3600
      conv(16'h0e11, 16'hffff);
      rd_reg(8'h43, 8'h0e);
      rd_reg(8'h44, 8'h10);
      rd_reg(8'h45, 8'h0e);
      rd_reg(8'h46, 8'h10);
      wr_reg(8'h43, 8'hff);
      wr_reg(8'h44, 8'hff);
      wr_reg(8'h45, 8'hff);
      wr_reg(8'h46, 8'hff);
      wr_reg(8'h48, 8'hff);
      rd_reg(8'h43, 8'h0e);
      rd_reg(8'h44, 8'h10);
      rd_reg(8'h45, 8'h0e);
      rd_reg(8'h46, 8'h10);
      rd_reg(8'h48, {2'h0, PART, REV});
      rd_reg(8'h50, 8'h00);
      rd_pair(8'h43, 16'h0123, 16'h0456, 16'h0e10);
      rd_pair(8'h45, 16'h0789, 16'h0abc, 16'h0456);
      rd_reg(8'h43, 8'h07);
      rd_reg(8'h44, 8'h89);
      rd_reg(8'h45, 8'h0a);
      rd_reg(8'h46, 8'hbc);
      for (int i = 0; i < 7; i++) begin
         drv({3'(i), 3'(6 - i), 2'(i)}, 3'(i), 3'(6 - i), 1'b0);
      end
      drv(8'he4, 3'h0, 3'h0, 1'b1);
      drv(8'hed, 3'h0, 3'h0, 1'b1);
      drv(8'hcb, 3'h6, 3'h2, 1'b0);
      do_reset;
      check(16'(dp_sel), 16'h0000);
      check(16'(dm_sel), 16'h0000);
      rd_reg(8'h47, 8'h00);
      rd_reg(8'h43, 8'h00);
      test_done;
   end

   // ----------------------------------------------------------------
   // watchdog: the sequence needs well under 4000 cycles
   // ----------------------------------------------------------------
   initial begin
      #20000;
      error_cnt++;
      test_done;
   end
endmodule : testbench
